// ---- hw/sdcr_regs.sv ----
// Contract
// - CRC bit appends CRC byte to reads
// - Tempco field selects magnet compensation
// - Averaging field sets samples per result
// - Conversion time follows averaging and axis count
// - Read-mode field selects read frame format
// - Interpretation 0 gives one signed threshold
// - Interpretation 1 gives two opposite thresholds
// - Bit 4 picks low noise or current
// - Bit 3 set disables I2C glitch filter
// - Bit 2 picks command or alert trigger
// - Trigger arriving during a triggered conversion is dropped
// - Extra triggers while pending are dropped
// - Trigger source matters only in standby
// - Mode field: standby, sleep, continuous, wake-sleep
// - Self exit to standby updates mode field
// - Sleep interval field spaces wake-sleep conversions
// - Direction ignored when interpretation above one
`timescale 1ns/100ps
`default_nettype none
`include "sdcr_cfg.svh"
module sdcr_regs #(
  parameter int unsigned CLK_HZ = `SDCR_CLK_HZ,
  parameter int unsigned MS_CYCLES = CLK_HZ / 1000
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic i2c_scl_i,
  input wire logic i2c_sda_i,
  output logic i2c_scl_clean_o,
  output logic i2c_sda_clean_o,
  output logic crc_append_o,
  output logic [1:0] read_frame_o,
  output logic [11:0] tempco_ppm_o,
  output logic [5:0] avg_samples_o,
  output logic low_noise_o,
  input wire logic [2:0][7:0] axis_threshold_value_i,
  input wire logic threshold_direction_i,
  output logic [2:0][7:0] thr_pos_o,
  output logic [2:0][7:0] thr_neg_o,
  output logic thr_dual_o,
  output logic thr_valid_o,
  output logic dir_below_o,
  output logic dir_valid_o,
  input wire logic single_axis_i,
  input wire logic [3:0] low_power_interval_i,
  input wire logic cmd_trig_i,
  input wire logic alert_n_i,
  input wire logic wake_exit_i,
  output logic [1:0] op_mode_o,
  output logic conv_start_o,
  output logic conv_busy_o,
  output logic conv_done_o
);

  // ***************************************************************
  // Helpers
  // ***************************************************************

  function automatic logic [23:0] sdcr_conv_cyc(input logic [2:0] code, input logic one_axis);
    logic [2:0] idx;
    logic [47:0] tab;
    logic [7:0] rate;
    logic [63:0] c;
    // Codes above 32x are undefined; they run as 32x
    idx = (code > 3'h5) ? 3'h5 : code;
    tab = one_axis ? `SDCR_RATE1_DKSPS : `SDCR_RATE3_DKSPS;
    rate = tab[{idx, 3'h0} +: 8];
    // Period rounds down so the documented rate is always met
    c = 64'(CLK_HZ) / (64'(rate) * 64'h64);
    if (c == 64'h0) begin
      c = 64'h1;
    end
    return c[23:0];
  endfunction : sdcr_conv_cyc

  function automatic logic [14:0] sdcr_nap_ms(input logic [3:0] code);
    logic [3:0] idx;
    logic [207:0] tab;
    idx = (code > `SDCR_NAP_CODES) ? `SDCR_NAP_CODES : code;
    tab = `SDCR_NAP_MS;
    return tab[{idx, 4'h0} +: 15];
  endfunction : sdcr_nap_ms

  function automatic logic [7:0] sdcr_mag(input logic [7:0] v);
    return {1'b0, v[6:0]};
  endfunction : sdcr_mag

  localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);

  sdcr_pkg::sdcr_main_s r;
  sdcr_pkg::sdcr_main_s n;

  sdcr_pkg::sdcr_opmode_e opm;
  logic [2:0] thi;
  logic alert_fall;
  logic trig;
  logic [23:0] conv_len;
  logic [14:0] nap_len;
  logic [1:0] raw_lines;
  logic [1:0] clean_lines;
  logic [2:0][7:0] pos_c;
  logic [2:0][7:0] neg_c;

  assign opm = sdcr_pkg::sdcr_opmode_e'(r.cfg2[`SDCR_OPM_HI:`SDCR_OPM_LO]);
  assign thi = r.cfg2[`SDCR_THI_HI:`SDCR_THI_LO];
  // Alert pin is active low; the second and third flops form the edge
  assign alert_fall = r.alert_s[2] & ~r.alert_s[1];
  assign conv_len = sdcr_conv_cyc(r.cfg1[`SDCR_AVG_HI:`SDCR_AVG_LO], single_axis_i);
  assign nap_len = sdcr_nap_ms(low_power_interval_i);

  // ***************************************************************
  // Bus line filters
  // ***************************************************************

  assign raw_lines = {i2c_sda_i, i2c_scl_i};

  for (genvar g = 0; g < 2; g++) begin : g_flt
    sdcr_flt_if fi ();
    assign fi.raw = raw_lines[g];
    assign fi.bypass = r.cfg2[`SDCR_GF_BIT];
    assign clean_lines[g] = fi.clean;
    sdcr_glitch u_flt (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .f(fi.filt)
    );
  end

  assign i2c_scl_clean_o = clean_lines[0];
  assign i2c_sda_clean_o = clean_lines[1];

  // ***************************************************************
  // Threshold shaping per axis
  // ***************************************************************

  for (genvar g = 0; g < 3; g++) begin : g_thr
    always_comb begin
      case (thi)
        3'h0: begin
          // Same signed value serves as the single limit
          pos_c[g] = axis_threshold_value_i[g];
          neg_c[g] = axis_threshold_value_i[g];
        end
        3'h1: begin
          pos_c[g] = sdcr_mag(axis_threshold_value_i[g]);
          neg_c[g] = 8'h00 - sdcr_mag(axis_threshold_value_i[g]);
        end
        default: begin
          // Reserved codes produce no limits at all
          pos_c[g] = 8'h00;
          neg_c[g] = 8'h00;
        end
      endcase
    end
  end

  // ***************************************************************
  // Next state
  // ***************************************************************

  always_comb begin
    n = r;
    n.start = 1'b0;
    n.done = 1'b0;
    n.rvalid = 1'b0;
    trig = 1'b0;

    n.alert_s = {r.alert_s[1], r.alert_s[0], alert_n_i};

    if (reg_wr_i) begin
      case (reg_addr_i)
        `SDCR_OFS_CFG1: n.cfg1 = reg_wdata_i;
        `SDCR_OFS_CFG2: n.cfg2 = reg_wdata_i;
        default: ;
      endcase
    end

    // Self exit wins over a host write in the same cycle, so the field
    // never claims wake-sleep once the sequencer has left it
    if (opm == sdcr_pkg::SDCR_OPM_WAKE && wake_exit_i) begin
      n.cfg2[`SDCR_OPM_HI:`SDCR_OPM_LO] = 2'(sdcr_pkg::SDCR_OPM_STANDBY);
    end

    if (reg_rd_i) begin
      n.rvalid = 1'b1;
      case (reg_addr_i)
        `SDCR_OFS_CFG1: n.rdata = r.cfg1;
        `SDCR_OFS_CFG2: n.rdata = r.cfg2;
        default: n.rdata = 8'h00;
      endcase
    end

    if (opm == sdcr_pkg::SDCR_OPM_STANDBY) begin
      trig = r.cfg2[`SDCR_TRG_BIT] ? alert_fall : cmd_trig_i;
    end

    if (opm != sdcr_pkg::SDCR_OPM_STANDBY) begin
      n.pending = 1'b0;
    end else if (trig && !r.pending && !r.trig_run) begin
      // One trigger is held; more while pending or triggered are lost
      n.pending = 1'b1;
    end

    case (r.st)
      sdcr_pkg::SDCR_IDLE: begin
        if (opm == sdcr_pkg::SDCR_OPM_CONT || opm == sdcr_pkg::SDCR_OPM_WAKE) begin
          n.st = sdcr_pkg::SDCR_CONV;
          n.conv_cnt = conv_len - 24'h1;
          n.start = 1'b1;
          n.busy = 1'b1;
        end else if (opm == sdcr_pkg::SDCR_OPM_STANDBY && r.pending) begin
          n.st = sdcr_pkg::SDCR_CONV;
          n.conv_cnt = conv_len - 24'h1;
          n.start = 1'b1;
          n.busy = 1'b1;
          n.pending = 1'b0;
          n.trig_run = 1'b1;
        end
      end
      sdcr_pkg::SDCR_CONV: begin
        // A conversion is never cut short by a mode or trigger change
        if (r.conv_cnt == 24'h0) begin
          n.done = 1'b1;
          n.busy = 1'b0;
          n.trig_run = 1'b0;
          n.ms_pre = 18'h0;
          n.ms_cnt = 15'h0;
          n.st = (opm == sdcr_pkg::SDCR_OPM_WAKE) ? sdcr_pkg::SDCR_NAP : sdcr_pkg::SDCR_IDLE;
        end else begin
          n.conv_cnt = r.conv_cnt - 24'h1;
        end
      end
      sdcr_pkg::SDCR_NAP: begin
        if (opm != sdcr_pkg::SDCR_OPM_WAKE) begin
          n.st = sdcr_pkg::SDCR_IDLE;
        end else if (r.ms_pre == MS_LAST) begin
          n.ms_pre = 18'h0;
          if (r.ms_cnt == nap_len - 15'h1) begin
            n.st = sdcr_pkg::SDCR_IDLE;
          end else begin
            n.ms_cnt = r.ms_cnt + 15'h1;
          end
        end else begin
          n.ms_pre = r.ms_pre + 18'h1;
        end
      end
      default: begin
        n.st = sdcr_pkg::SDCR_IDLE;
      end
    endcase

    // ***************************************************************
    // Decoded configuration
    // ***************************************************************

    n.crc = r.cfg1[`SDCR_CRC_BIT];
    n.rdm = r.cfg1[`SDCR_RDM_HI:`SDCR_RDM_LO];
    case (r.cfg1[`SDCR_TC_HI:`SDCR_TC_LO])
      2'h1: n.tc_ppm = `SDCR_TC1_PPM;
      2'h3: n.tc_ppm = `SDCR_TC3_PPM;
      default: n.tc_ppm = 12'h000;
    endcase
    if (r.cfg1[`SDCR_AVG_HI:`SDCR_AVG_LO] > 3'h5) begin
      n.avg = 6'h20;
    end else begin
      n.avg = 6'h01 << r.cfg1[`SDCR_AVG_HI:`SDCR_AVG_LO];
    end
    n.ln = r.cfg2[`SDCR_LN_BIT];

    n.thr_pos = pos_c;
    n.thr_neg = neg_c;
    n.thr_dual = (thi == 3'h1);
    n.thr_valid = (thi <= 3'h1);
    // Direction only means something for the two defined codes
    n.dir_valid = (thi <= 3'h1);
    n.dir_below = (thi <= 3'h1) ? threshold_direction_i : 1'b0;
  end

  // ***************************************************************
  // State register
  // ***************************************************************

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      r <= '0;
      r.cfg1 <= `SDCR_CFG1_RST;
      r.cfg2 <= `SDCR_CFG2_RST;
      r.alert_s <= 3'h7;
      r.avg <= 6'h01;
      r.thr_valid <= 1'b1;
      r.dir_valid <= 1'b1;
    end else if (ce_i) begin
      r <= n;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************

  assign reg_rdata_o = r.rdata;
  assign reg_rvalid_o = r.rvalid;
  assign crc_append_o = r.crc;
  assign read_frame_o = r.rdm;
  assign tempco_ppm_o = r.tc_ppm;
  assign avg_samples_o = r.avg;
  assign low_noise_o = r.ln;
  assign thr_pos_o = r.thr_pos;
  assign thr_neg_o = r.thr_neg;
  assign thr_dual_o = r.thr_dual;
  assign thr_valid_o = r.thr_valid;
  assign dir_below_o = r.dir_below;
  assign dir_valid_o = r.dir_valid;
  assign op_mode_o = r.cfg2[`SDCR_OPM_HI:`SDCR_OPM_LO];
  assign conv_start_o = r.start;
  assign conv_busy_o = r.busy;
  assign conv_done_o = r.done;

endmodule : sdcr_regs
`default_nettype wire

// ---- hw/sdcr_cfg.svh ----
`ifndef SDCR_CFG_SVH
`define SDCR_CFG_SVH

`define SDCR_CLK_HZ 250000000
`define SDCR_OFS_CFG1 5'h00
`define SDCR_OFS_CFG2 5'h01
`define SDCR_CFG1_RST 8'h00
`define SDCR_CFG2_RST 8'h00
`define SDCR_CRC_BIT 7
`define SDCR_TC_HI 6
`define SDCR_TC_LO 5
`define SDCR_AVG_HI 4
`define SDCR_AVG_LO 2
`define SDCR_RDM_HI 1
`define SDCR_RDM_LO 0
`define SDCR_THI_HI 7
`define SDCR_THI_LO 5
`define SDCR_LN_BIT 4
`define SDCR_GF_BIT 3
`define SDCR_TRG_BIT 2
`define SDCR_OPM_HI 1
`define SDCR_OPM_LO 0
`define SDCR_TC1_PPM 12'h4B0
`define SDCR_TC3_PPM 12'h7D0
// Output rates in tenths of kSPS, code 0 in the low byte
`define SDCR_RATE3_DKSPS {8'h04, 8'h08, 8'h10, 8'h1F, 8'h39, 8'h64}
`define SDCR_RATE1_DKSPS {8'h0C, 8'h18, 8'h2C, 8'h50, 8'h85, 8'hC8}
// Sleep intervals in ms, code 0 in the low half-word
`define SDCR_NAP_MS {16'h4E20, 16'h1388, 16'h07D0, 16'h03E8, 16'h01F4, 16'h0064, \
  16'h0032, 16'h001E, 16'h0014, 16'h000F, 16'h000A, 16'h0005, 16'h0001}
`define SDCR_NAP_CODES 4'hC
`define SDCR_GLITCH_NS 50

`endif

// ---- hw/sdcr_pkg.sv ----
package sdcr_pkg;

  typedef enum logic [1:0] {
    SDCR_OPM_STANDBY,
    SDCR_OPM_SLEEP,
    SDCR_OPM_CONT,
    SDCR_OPM_WAKE
  } sdcr_opmode_e;

  typedef enum logic [1:0] {
    SDCR_IDLE,
    SDCR_CONV,
    SDCR_NAP
  } sdcr_seq_e;

  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] rdata;
    logic rvalid;
    logic [2:0] alert_s;
    sdcr_seq_e st;
    logic [23:0] conv_cnt;
    logic [17:0] ms_pre;
    logic [14:0] ms_cnt;
    logic pending;
    logic trig_run;
    logic start;
    logic done;
    logic busy;
    logic crc;
    logic [1:0] rdm;
    logic [11:0] tc_ppm;
    logic [5:0] avg;
    logic ln;
    logic [2:0][7:0] thr_pos;
    logic [2:0][7:0] thr_neg;
    logic thr_dual;
    logic thr_valid;
    logic dir_below;
    logic dir_valid;
  } sdcr_main_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic clean;
    logic [3:0] cnt;
  } sdcr_flt_s;

endpackage : sdcr_pkg

// ---- hw/sdcr_flt_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface sdcr_flt_if;
  logic raw;
  logic bypass;
  logic clean;
  modport filt (input raw, input bypass, output clean);
  modport user (output raw, output bypass, input clean);
endinterface : sdcr_flt_if
`default_nettype wire

// ---- hw/sdcr_glitch.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sdcr_cfg.svh"
module sdcr_glitch (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ce_i,
  sdcr_flt_if.filt f
);
  localparam longint unsigned GL_RAW =
    (64'(`SDCR_GLITCH_NS) * 64'(`SDCR_CLK_HZ) + 64'h3B9AC9FF) / 64'h3B9ACA00;
  localparam logic [3:0] GL_CYC = (GL_RAW < 64'h1) ? 4'h1 : 4'(GL_RAW);

  sdcr_pkg::sdcr_flt_s r;
  sdcr_pkg::sdcr_flt_s n;

  always_comb begin
    n = r;
    n.s1 = f.raw;
    n.s2 = r.s1;
    if (f.bypass) begin
      // Filter off: synchronised level passes straight on
      n.clean = r.s2;
      n.cnt = 4'h0;
    end else if (r.s2 == r.clean) begin
      n.cnt = 4'h0;
    end else if (r.cnt == GL_CYC - 4'h1) begin
      // Level must hold for the whole window before it is believed
      n.clean = r.s2;
      n.cnt = 4'h0;
    end else begin
      n.cnt = r.cnt + 4'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      r <= '0;
      r.s1 <= 1'b1;
      r.s2 <= 1'b1;
      r.clean <= 1'b1;
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign f.clean = r.clean;

endmodule : sdcr_glitch
`default_nettype wire

// ---- testbench/sdcr_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdcr_checker (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic crc_append_o,
  input wire logic [1:0] read_frame_o,
  input wire logic [11:0] tempco_ppm_o,
  input wire logic [5:0] avg_samples_o,
  input wire logic low_noise_o,
  input wire logic thr_valid_o,
  input wire logic cmd_trig_i,
  input wire logic wake_exit_i,
  input wire logic [1:0] op_mode_o,
  input wire logic conv_start_o,
  input wire logic conv_busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  logic w0;
  logic w1;
  logic trg_r;
  assign w0 = reg_wr_i && reg_addr_i == 5'h00;
  assign w1 = reg_wr_i && reg_addr_i == 5'h01;
  // Trigger source has no port, so it is tracked from the writes
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      trg_r <= 1'b0;
    end else if (w1) begin
      trg_r <= reg_wdata_i[2];
    end
  end
  // ********
  // Properties
  // ********
  // Decoded outputs trail the register by one more edge
  a_primary_decode:
  assert property (w0 |=> ##1 {crc_append_o, read_frame_o} == $past({reg_wdata_i[7], reg_wdata_i[1:0]}, 2))
    else $error("crc or frame decode wrong");
  a_tempco_map:
  assert property (w0 |=> ##1 tempco_ppm_o == ($past(reg_wdata_i[6:5], 2) == 2'h1 ? 12'h4B0 :
    $past(reg_wdata_i[6:5], 2) == 2'h3 ? 12'h7D0 : 12'h000)) else $error("tempco wrong");
  a_avg_map:
  assert property (w0 |=> ##1 avg_samples_o == ($past(reg_wdata_i[4:2], 2) > 3'h5 ? 6'h20 :
    6'h01 << $past(reg_wdata_i[4:2], 2))) else $error("averaging wrong");
  a_second_decode:
  assert property (w1 |=> ##1 low_noise_o == $past(reg_wdata_i[4], 2) &&
    thr_valid_o == ($past(reg_wdata_i[7:5], 2) <= 3'h1)) else $error("secondary decode wrong");
  a_opmode_write:
  assert property (w1 && !wake_exit_i |=> op_mode_o == $past(reg_wdata_i[1:0])) else $error("mode write lost");
  a_wake_exit:
  assert property (wake_exit_i && op_mode_o == 2'h3 |=> op_mode_o == 2'h0) else $error("mode not standby");
  a_no_overlap:
  assert property (conv_start_o |-> conv_busy_o && !$past(conv_busy_o)) else $error("start while busy");
  a_cmd_start:
  assert property (cmd_trig_i && !trg_r && op_mode_o == 2'h0 && !conv_busy_o && !$past(cmd_trig_i)
    |=> ##1 conv_start_o) else $error("command trigger missed");
  a_busy_span:
  assert property (conv_start_o |=> conv_busy_o [*8]) else $error("conversion too short");
  c_cmd_conv: cover property (cmd_trig_i ##2 conv_start_o);
  c_wake_exit: cover property (wake_exit_i && op_mode_o == 2'h3);
  c_conv: cover property (conv_start_o);
endmodule : sdcr_checker
bind sdcr_regs sdcr_checker chk_u (.*);
`default_nettype wire

// ---- testbench/sdcr_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdcr_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic [4:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  initial begin
    addr_o = 5'h1F;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // Up to two idle cycles before a request, so both prompt and slow hosts are seen
  task automatic xfer(input logic [4:0] a, input logic w, input logic [7:0] d, output logic [8:0] r);
    repeat ($urandom_range(2, 0)) @(posedge clk_i);
    #1;
    addr_o = a;
    wr_o = w;
    rd_o = !w;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    r = {rvalid_i, rdata_i};
    wr_o = 1'b0;
    rd_o = 1'b0;
    // Released lines show the inverse rather than a stale copy
    addr_o = ~a;
    wdata_o = ~d;
  endtask : xfer
endmodule : sdcr_host
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic i2c_scl_i = 1'b1;
  logic i2c_sda_i = 1'b1;
  logic [2:0][7:0] axis_threshold_value_i = 24'h000000;
  logic threshold_direction_i = 1'b0;
  logic single_axis_i = 1'b0;
  logic [3:0] low_power_interval_i = 4'h0;
  logic cmd_trig_i = 1'b0;
  logic alert_n_i = 1'b1;
  logic wake_exit_i = 1'b0;
  wire [4:0] reg_addr_i;
  wire reg_wr_i, reg_rd_i, reg_rvalid_o, i2c_scl_clean_o, i2c_sda_clean_o, crc_append_o, low_noise_o;
  wire thr_dual_o, thr_valid_o, dir_below_o, dir_valid_o, conv_start_o, conv_busy_o, conv_done_o;
  wire [7:0] reg_wdata_i, reg_rdata_o;
  wire [1:0] read_frame_o, op_mode_o;
  wire [11:0] tempco_ppm_o;
  wire [5:0] avg_samples_o;
  wire [2:0][7:0] thr_pos_o, thr_neg_o;
  int fail_count = 0;
  int n_tests = 0;
  int mdl [2] = '{0, 0};
  int n;
  // Rates in tenths of kSPS; at 1 MHz a conversion lasts 1e6 / (rate * 100) cycles
  int rate3 [6] = '{100, 57, 31, 16, 8, 4};
  int rate1 [6] = '{200, 133, 80, 44, 24, 12};
  int ms [3] = '{1, 5, 10};
  logic [7:0] tm [5] = '{8'h04, 8'h04, 8'h01, 8'h05, 8'h00};
  logic ta [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  // The pin path adds two sync stages before the edge flop sees the fall
  int tl [5] = '{8, 2, 8, 8, 8};
  logic [8:0] r;
  logic [7:0] d;
  logic [4:0] ua;
  sdcr_regs #(.CLK_HZ(1000000), .MS_CYCLES(10)) dut_u (.*);
  sdcr_host host_u (.clk_i(clock_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o), .addr_o(reg_addr_i),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    host_u.xfer(a, 1'b1, v, r);
    if (a < 5'h02) mdl[a] = v;
    cyc(2);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    host_u.xfer(a, 1'b0, 8'h00, r);
    chk("rdata", r, {1'b1, a < 5'h02 ? mdl[a][7:0] : 8'h00});
  endtask : rd
  task automatic dwait();
    n = 0;
    while (!conv_done_o && n < 3000) begin
      cyc(1);
      n++;
    end
  endtask : dwait
  task automatic chk_dec();
    int it;
    int tc;
    logic [7:0] v;
    logic [7:0] q;
    it = mdl[1] >> 5;
    tc = (mdl[0] >> 5) & 3;
    chk("crc", crc_append_o, mdl[0] >> 7);
    chk("frame", read_frame_o, mdl[0] & 3);
    chk("tempco", tempco_ppm_o, tc == 1 ? 1200 : tc == 3 ? 2000 : 0);
    chk("avg", avg_samples_o, 1 << (((mdl[0] >> 2) & 7) > 5 ? 5 : (mdl[0] >> 2) & 7));
    chk("noise", low_noise_o, (mdl[1] >> 4) & 1);
    chk("mode", op_mode_o, mdl[1] & 3);
    chk("dual", thr_dual_o, it == 1);
    chk("dir", {thr_valid_o, dir_valid_o, dir_below_o}, it < 2 ? 6 + threshold_direction_i : 0);
    for (int i = 0; i < 3; i++) begin
      v = it == 1 ? {1'b0, axis_threshold_value_i[i][6:0]} : axis_threshold_value_i[i];
      q = it == 1 ? -v : v;
      chk("pos", thr_pos_o[i], it < 2 ? v : 8'h00);
      chk("neg", thr_neg_o[i], it < 2 ? q : 8'h00);
    end
  endtask : chk_dec
  // A second command trigger one cycle later must be dropped, not queued
  task automatic fire(input logic al, input int lat);
    while (conv_busy_o) cyc(1);
    cmd_trig_i = !al;
    alert_n_i = !al;
    cyc(1);
    cmd_trig_i = !al;
    alert_n_i = 1'b1;
    cyc(1);
    cmd_trig_i = 1'b0;
    n = 0;
    while (!conv_start_o && n < 8) begin
      cyc(1);
      n++;
    end
    chk("latency", n, lat);
    if (lat < 8) dwait();
  endtask : fire
  initial begin
    #160000;
    fail_count++;
    test_done();
  end
  initial begin
    void'($urandom(65));
    cyc(4);
    srst_i = 1'b0;
    cyc(1);
    rd(5'h00);
    rd(5'h01);
    chk_dec();
    for (int i = 0; i < 16; i++) begin
      axis_threshold_value_i = 24'($urandom);
      threshold_direction_i = 1'($urandom);
      d = 8'($urandom);
      if (i[0]) d[7:5] = 3'(i / 2);
      else d[4:2] = 3'(i / 2);
      if (!i[0] && d[6:5] == 2'h2) d[5] = 1'b1;
      wr(5'(i % 2), d);
      chk_dec();
      rd(5'(i % 2));
    end
    wr(5'h01, 8'h00);
    for (int c = 0; c < 6; c++) begin
      single_axis_i = 1'($urandom);
      wr(5'h00, 8'(c << 2));
      fire(1'b0, 0);
      chk("length", n, 1000000 / ((single_axis_i ? rate1[c] : rate3[c]) * 100));
      cyc(4);
      chk("idle", conv_busy_o, 1'b0);
    end
    wr(5'h00, 8'h00);
    for (int t = 0; t < 5; t++) begin
      wr(5'h01, tm[t]);
      fire(ta[t], tl[t]);
    end
    wr(5'h01, 8'h02);
    dwait();
    cyc(1);
    chk("restart", conv_start_o, 1'b1);
    low_power_interval_i = 4'($urandom_range(2, 0));
    wr(5'h01, 8'h03);
    dwait();
    n = 0;
    while (!conv_start_o && n < 200) begin
      cyc(1);
      n++;
    end
    chk("nap", n >= ms[low_power_interval_i] * 10 && n <= ms[low_power_interval_i] * 10 + 3, 1'b1);
    wake_exit_i = 1'b1;
    cyc(1);
    wake_exit_i = 1'b0;
    mdl[1] = 0;
    chk("exit", op_mode_o, 2'h0);
    rd(5'h01);
    for (int g = 0; g < 2; g++) begin
      wr(5'h01, g ? 8'h08 : 8'h00);
      i2c_scl_i = 1'b0;
      i2c_sda_i = 1'b0;
      cyc(3);
      i2c_scl_i = 1'b1;
      i2c_sda_i = 1'b1;
      n = 0;
      repeat (20) begin
        cyc(1);
        n += !i2c_scl_clean_o;
        chk("sda", i2c_sda_clean_o, i2c_scl_clean_o);
      end
      chk("glitch", n > 0, g);
    end
    ua = 5'($urandom_range(31, 2));
    wr(ua, 8'hFF);
    rd(ua);
    rd(5'h00);
    rd(5'h01);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
